// ---- dpg_params.svh ----
// Register map, reset values and field positions for the dual GPIO port
// Behaviour
// - Port A keeps one data latch per pin; reset leaves it unchanged.
// - Port A direction bit 1 enables the output driver, 0 makes an input.
// - Reset clears all port A direction bits.
// - Port A data read gives latch for outputs, pin level for inputs.
// - Data latch writes always land; inputs still read the pin.
// - Port A pull-up on only when its enable is 1 and direction is 0.
// - Output direction disables pull-up without changing the stored enable.
// - RC option: reuse bit 1 makes oscillator pin GPIO 6, 0 outputs RC clock.
// - Reuse bit is read/write but inert with the crystal option.
// - Key interrupt enable bits turn port A pins into interrupt inputs.
// - The port A option bit and the serial enable together hand port A pins 2 and 3 to the two-wire serial block.
// - Port B keeps one data latch per pin; reset leaves it unchanged.
// - Port B direction bit 1 enables the output driver, 0 disables it.
// - Reset clears all port B direction bits.
// - Port B data read gives latch for outputs, pin level for inputs.
`ifndef DPG_PARAMS_SVH
`define DPG_PARAMS_SVH
`define DPG_ADDR_W        8
`define DPG_OFF_PA_DATA   8'h00
`define DPG_OFF_PB_DATA   8'h01
`define DPG_OFF_PA_DIR    8'h04
`define DPG_OFF_PB_DIR    8'h05
`define DPG_OFF_PA_PUE    8'h0D
`define DPG_OFF_PIN7_PUE  8'h0E
`define DPG_DIR_RST       8'h00
`define DPG_PUE_RST       8'h00
`define DPG_PIN7_RST      8'h00
`define DPG_REUSE_BIT     7
`define DPG_OSC_PIN       6
`define DPG_TW_SDA_PIN    2
`define DPG_TW_SCL_PIN    3
`define DPG_SYNC_STAGES   2
`endif

// ---- dpg_pkg.sv ----
// Types shared by the dual GPIO port modules
package dpg_pkg;
  typedef logic [7:0] dpg_byte_t;
  typedef enum logic [2:0] {
    DPG_SEL_NONE,
    DPG_SEL_PA_DATA,
    DPG_SEL_PB_DATA,
    DPG_SEL_PA_DIR,
    DPG_SEL_PB_DIR,
    DPG_SEL_PA_PUE,
    DPG_SEL_PIN7_PUE
  } dpg_sel_e;
endpackage : dpg_pkg

// ---- dpg_sync.sv ----
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module dpg_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             clk_en,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : dpg_sync

// ---- dpg_pin_mux.sv ----
// Per-pin read multiplexer: latch for outputs, pin for inputs
`timescale 1ns/1ps
module dpg_pin_mux #(
  parameter int WIDTH = 8
) (
  // Selection
  input  wire logic [WIDTH-1:0] dir,
  input  wire logic [WIDTH-1:0] latch,
  input  wire logic [WIDTH-1:0] pin,
  // Result
  output logic      [WIDTH-1:0] rd
);
  assign rd = (dir & latch) | (~dir & pin);
endmodule : dpg_pin_mux

// ---- dpg_gpio.sv ----
// Dual 8-bit GPIO port with port A pull-ups, overrides and register port
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "dpg_params.svh"
module dpg_gpio #(
  parameter int WIDTH = 8
) (
  // Clock, reset, enable
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic                   clk_en,
  // Register port
  input  wire logic [`DPG_ADDR_W-1:0] addr,
  input  wire logic [7:0]             wdata,
  input  wire logic                   wr_stb,
  input  wire logic                   rd_stb,
  output logic      [7:0]             rdata,
  // Option straps
  input  wire logic                   rc_osc_sel,
  input  wire logic                   tw_on_port_a,
  input  wire logic                   tw_enable,
  input  wire logic [WIDTH-1:0]       key_irq_pin_enable,
  // Two-wire serial override for port A pins 2 and 3, RC clock for pin 6
  input  wire logic                   tw_sda_o,
  input  wire logic                   tw_sda_oe,
  input  wire logic                   tw_scl_o,
  input  wire logic                   tw_scl_oe,
  input  wire logic                   rc_clock_output,
  // Port A pins
  input  wire logic [WIDTH-1:0]       pa_i,
  output logic      [WIDTH-1:0]       pa_o,
  output logic      [WIDTH-1:0]       pa_oe,
  output logic      [WIDTH-1:0]       pa_pullup,
  // Port B pins
  input  wire logic [WIDTH-1:0]       pb_i,
  output logic      [WIDTH-1:0]       pb_o,
  output logic      [WIDTH-1:0]       pb_oe,
  // Hooks to shared modules
  output logic      [WIDTH-1:0]       key_irq_level,
  output logic      [WIDTH-1:0]       key_irq_active,
  output logic                        tw_sda_i,
  output logic                        tw_scl_i
);
  logic [WIDTH-1:0] port_a_latch;
  logic [WIDTH-1:0] port_b_latch;
  logic [WIDTH-1:0] port_a_direction_bits;
  logic [WIDTH-1:0] port_b_direction_bits;
  logic [WIDTH-1:0] port_a_pullup_bits;
  logic [7:0]       pin7_pullup_reg;
  logic [WIDTH-1:0] pa_sync;
  logic [WIDTH-1:0] pb_sync;
  logic [WIDTH-1:0] pa_rd;
  logic [WIDTH-1:0] pb_rd;
  logic             osc_pin_reuse_select;
  logic             osc_gpio;
  logic             tw_take;
  dpg_pkg::dpg_sel_e sel;

  // Checks below share one clock and are off while reset is held
  default clocking cb_main @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  function automatic dpg_pkg::dpg_sel_e dec(input logic [7:0] a);
    case (a)
      `DPG_OFF_PA_DATA:  dec = dpg_pkg::DPG_SEL_PA_DATA;
      `DPG_OFF_PB_DATA:  dec = dpg_pkg::DPG_SEL_PB_DATA;
      `DPG_OFF_PA_DIR:   dec = dpg_pkg::DPG_SEL_PA_DIR;
      `DPG_OFF_PB_DIR:   dec = dpg_pkg::DPG_SEL_PB_DIR;
      `DPG_OFF_PA_PUE:   dec = dpg_pkg::DPG_SEL_PA_PUE;
      `DPG_OFF_PIN7_PUE: dec = dpg_pkg::DPG_SEL_PIN7_PUE;
      default:           dec = dpg_pkg::DPG_SEL_NONE;
    endcase
  endfunction : dec

  assign sel = dec(addr);
  assign osc_pin_reuse_select = pin7_pullup_reg[`DPG_REUSE_BIT];

  // Latches have no reset on purpose: contents survive reset
  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_stb && sel == dpg_pkg::DPG_SEL_PA_DATA) begin
      port_a_latch <= wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_stb && sel == dpg_pkg::DPG_SEL_PB_DATA) begin
      port_b_latch <= wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_a_direction_bits <= `DPG_DIR_RST;
    end else if (clk_en && wr_stb && sel == dpg_pkg::DPG_SEL_PA_DIR) begin
      port_a_direction_bits <= wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_b_direction_bits <= `DPG_DIR_RST;
    end else if (clk_en && wr_stb && sel == dpg_pkg::DPG_SEL_PB_DIR) begin
      port_b_direction_bits <= wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_a_pullup_bits <= `DPG_PUE_RST;
    end else if (clk_en && wr_stb && sel == dpg_pkg::DPG_SEL_PA_PUE) begin
      port_a_pullup_bits <= wdata[WIDTH-1:0];
    end
  end

  // Reuse bit stored even with crystal option so software reads it back
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin7_pullup_reg <= `DPG_PIN7_RST;
    end else if (clk_en && wr_stb && sel == dpg_pkg::DPG_SEL_PIN7_PUE) begin
      pin7_pullup_reg <= wdata;
    end
  end

  dpg_sync #(.WIDTH(WIDTH)) u_sync_a (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .clk_en   (clk_en),
    .async_in (pa_i),
    .sync_out (pa_sync)
  );

  dpg_sync #(.WIDTH(WIDTH)) u_sync_b (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .clk_en   (clk_en),
    .async_in (pb_i),
    .sync_out (pb_sync)
  );

  dpg_pin_mux #(.WIDTH(WIDTH)) u_mux_a (
    .dir   (port_a_direction_bits),
    .latch (port_a_latch),
    .pin   (pa_sync),
    .rd    (pa_rd)
  );

  dpg_pin_mux #(.WIDTH(WIDTH)) u_mux_b (
    .dir   (port_b_direction_bits),
    .latch (port_b_latch),
    .pin   (pb_sync),
    .rd    (pb_rd)
  );

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (clk_en) begin
      rdata <= 8'h00;
      if (rd_stb) begin
        case (sel)
          dpg_pkg::DPG_SEL_PA_DATA:  rdata <= pa_rd;
          dpg_pkg::DPG_SEL_PB_DATA:  rdata <= pb_rd;
          dpg_pkg::DPG_SEL_PA_DIR:   rdata <= port_a_direction_bits;
          dpg_pkg::DPG_SEL_PB_DIR:   rdata <= port_b_direction_bits;
          dpg_pkg::DPG_SEL_PA_PUE:   rdata <= port_a_pullup_bits;
          dpg_pkg::DPG_SEL_PIN7_PUE: rdata <= pin7_pullup_reg;
          default:                   rdata <= 8'h00;
        endcase
      end
    end
  end

  // Pin 6 is GPIO with crystal option or when reuse is set
  assign osc_gpio = !rc_osc_sel || osc_pin_reuse_select;
  assign tw_take  = tw_on_port_a && tw_enable;

  always_comb begin
    pa_o  = port_a_latch;
    pa_oe = port_a_direction_bits;
    if (rc_osc_sel && !osc_pin_reuse_select) begin
      pa_o[`DPG_OSC_PIN]  = rc_clock_output;
      pa_oe[`DPG_OSC_PIN] = 1'b1;
    end
    // Serial block wins over keyboard and port logic on its pins
    if (tw_take) begin
      pa_o[`DPG_TW_SDA_PIN]  = tw_sda_o;
      pa_oe[`DPG_TW_SDA_PIN] = tw_sda_oe;
      pa_o[`DPG_TW_SCL_PIN]  = tw_scl_o;
      pa_oe[`DPG_TW_SCL_PIN] = tw_scl_oe;
    end
  end

  always_comb begin
    pa_pullup = port_a_pullup_bits & ~port_a_direction_bits;
    if (!osc_gpio) begin
      pa_pullup[`DPG_OSC_PIN] = 1'b0;
    end
  end

  assign pb_o  = port_b_latch;
  assign pb_oe = port_b_direction_bits;

  always_comb begin
    key_irq_active = key_irq_pin_enable;
    if (!osc_gpio) begin
      key_irq_active[`DPG_OSC_PIN] = 1'b0;
    end
    if (tw_take) begin
      key_irq_active[`DPG_TW_SDA_PIN] = 1'b0;
      key_irq_active[`DPG_TW_SCL_PIN] = 1'b0;
    end
  end

  assign key_irq_level = pa_sync;
  assign tw_sda_i      = pa_sync[`DPG_TW_SDA_PIN];
  assign tw_scl_i      = pa_sync[`DPG_TW_SCL_PIN];

  // Assertions
  // Data latches have no reset, so hold checks wait for a first write
  logic [WIDTH-1:0] pa_lat_prev_r;
  logic [WIDTH-1:0] pb_lat_prev_r;
  logic             pa_seen_r;
  logic             pb_seen_r;

  always_ff @(posedge ref_clk) begin
    pa_lat_prev_r <= port_a_latch;
  end

  always_ff @(posedge ref_clk) begin
    pb_lat_prev_r <= port_b_latch;
  end

  // Left unknown until a first write, so no reset can fake one
  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_stb && sel == dpg_pkg::DPG_SEL_PA_DATA) begin
      pa_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_stb && sel == dpg_pkg::DPG_SEL_PB_DATA) begin
      pb_seen_r <= 1'b1;
    end
  end

  sequence s_rd_pa;
    clk_en && rd_stb && sel == dpg_pkg::DPG_SEL_PA_DATA;
  endsequence

  sequence s_rd_pb;
    clk_en && rd_stb && sel == dpg_pkg::DPG_SEL_PB_DATA;
  endsequence

  sequence s_wr_pa;
    clk_en && wr_stb && sel == dpg_pkg::DPG_SEL_PA_DATA;
  endsequence

  sequence s_wr_pb;
    clk_en && wr_stb && sel == dpg_pkg::DPG_SEL_PB_DATA;
  endsequence

  sequence s_wr_pa_dir;
    clk_en && wr_stb && sel == dpg_pkg::DPG_SEL_PA_DIR;
  endsequence

  sequence s_wr_pb_dir;
    clk_en && wr_stb && sel == dpg_pkg::DPG_SEL_PB_DIR;
  endsequence

  sequence s_wr_pue;
    clk_en && wr_stb && sel == dpg_pkg::DPG_SEL_PA_PUE;
  endsequence

  sequence s_wr_reuse;
    clk_en && wr_stb && sel == dpg_pkg::DPG_SEL_PIN7_PUE;
  endsequence

  AST_PA_LATCH_WR: assert property (s_wr_pa |=>
    port_a_latch == $past(wdata))
    else $error("port A latch missed a write");
  AST_PB_LATCH_WR: assert property (s_wr_pb |=>
    port_b_latch == $past(wdata))
    else $error("port B latch missed a write");
  AST_PA_HOLD: assert property (pa_seen_r &&
    !(wr_stb && sel == dpg_pkg::DPG_SEL_PA_DATA) |=>
    port_a_latch == pa_lat_prev_r)
    else $error("port A latch changed without write");
  AST_PB_HOLD: assert property (pb_seen_r &&
    !(wr_stb && sel == dpg_pkg::DPG_SEL_PB_DATA) |=>
    port_b_latch == pb_lat_prev_r)
    else $error("port B latch changed without write");
  AST_PA_DIR_WR: assert property (s_wr_pa_dir |=>
    port_a_direction_bits == $past(wdata))
    else $error("port A direction missed a write");
  AST_PB_DIR_WR: assert property (s_wr_pb_dir |=>
    port_b_direction_bits == $past(wdata))
    else $error("port B direction missed a write");
  AST_PA_DIR_OE: assert property (!tw_take && !rc_osc_sel |->
    pa_oe == port_a_direction_bits)
    else $error("port A enable differs from direction");
  AST_PB_DIR_OE: assert property (pb_oe == port_b_direction_bits)
    else $error("port B enable differs from direction");
  AST_PA_DIR_RST: assert property ($rose(rstn) |->
    port_a_direction_bits == 8'h00)
    else $error("port A direction not cleared");
  AST_PB_DIR_RST: assert property ($rose(rstn) |->
    port_b_direction_bits == 8'h00)
    else $error("port B direction not cleared");
  AST_PA_READ: assert property (s_rd_pa ##1 clk_en |->
    rdata == (($past(port_a_direction_bits) & $past(port_a_latch))
      | (~$past(port_a_direction_bits) & $past(pa_sync))))
    else $error("port A read wrong");
  AST_PB_READ: assert property (s_rd_pb |=>
    rdata == $past(pb_rd))
    else $error("port B read wrong");
  AST_PUE_WR: assert property (s_wr_pue |=>
    port_a_pullup_bits == $past(wdata))
    else $error("pull-up enables missed a write");
  AST_PULLUP_IN: assert property (osc_gpio |->
    pa_pullup == (port_a_pullup_bits & ~port_a_direction_bits))
    else $error("pull-up differs from enable and direction");
  AST_PULLUP: assert property (
    (pa_pullup & port_a_direction_bits) == 8'h00)
    else $error("pull-up on an output pin");
  AST_OSC_CLK: assert property (rc_osc_sel &&
    !osc_pin_reuse_select |-> pa_o[`DPG_OSC_PIN] == rc_clock_output
    && pa_oe[`DPG_OSC_PIN] && !pa_pullup[`DPG_OSC_PIN])
    else $error("oscillator pin not driving RC clock");
  AST_REUSE_WR: assert property (s_wr_reuse |=>
    osc_pin_reuse_select == $past(wdata[`DPG_REUSE_BIT]))
    else $error("reuse bit missed a write");
  AST_XTAL_PIN: assert property (!rc_osc_sel |->
    pa_oe[`DPG_OSC_PIN] == port_a_direction_bits[`DPG_OSC_PIN])
    else $error("crystal option moved the oscillator pin");
  AST_KEY_EN: assert property (osc_gpio && !tw_take |->
    key_irq_active == key_irq_pin_enable)
    else $error("key interrupt enables not passed on");
  AST_TW_KEY: assert property (tw_take |->
    !key_irq_active[`DPG_TW_SDA_PIN] && !key_irq_active[`DPG_TW_SCL_PIN])
    else $error("key interrupt left on a serial pin");
  AST_TW_PINS: assert property (tw_take |->
    pa_oe[`DPG_TW_SDA_PIN] == tw_sda_oe && pa_o[`DPG_TW_SDA_PIN] == tw_sda_o
    && pa_oe[`DPG_TW_SCL_PIN] == tw_scl_oe
    && pa_o[`DPG_TW_SCL_PIN] == tw_scl_o)
    else $error("serial block does not own its pins");
  AST_RD_IDLE: assert property (clk_en && !rd_stb |=> rdata == 8'h00)
    else $error("read data outside read slot");
endmodule : dpg_gpio

// ---- dpg_board.sv ----
// Board-side model of the pins on both ports
`timescale 1ns/1ps
module dpg_board (
  // Clock
  input  wire logic       ref_clk,
  // Device drive
  input  wire logic [7:0] pa_o,
  input  wire logic [7:0] pa_oe,
  input  wire logic [7:0] pa_pullup,
  input  wire logic [7:0] pb_o,
  input  wire logic [7:0] pb_oe,
  // Board drive
  input  wire logic [7:0] ext_a,
  input  wire logic [7:0] ext_a_en,
  input  wire logic [7:0] ext_b,
  input  wire logic [7:0] ext_b_en,
  // Pin levels
  output logic      [7:0] pa_i,
  output logic      [7:0] pb_i
);
  logic [7:0] flt_r = 8'h00;
  // Floating lines wander so no stale level can pass for a real one
  always @(posedge ref_clk) flt_r <= ~flt_r;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pa_i[i] = pa_oe[i] ? pa_o[i] : ext_a_en[i] ? ext_a[i] :
                pa_pullup[i] ? 1'b1 : flt_r[i];
      pb_i[i] = pb_oe[i] ? pb_o[i] : ext_b_en[i] ? ext_b[i] : flt_r[i];
    end
  end
endmodule : dpg_board

// ---- testbench.sv ----
// Register-level tests of the dual GPIO port
`timescale 1ns/1ps
`include "dpg_params.svh"
module testbench;
  logic       ref_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, kie = 8'h00;
  logic       wr_stb = 1'b0, rd_stb = 1'b0, rc_osc_sel = 1'b0;
  logic       tw_on_port_a = 1'b0, tw_enable = 1'b0, rc_clock_output = 1'b0;
  logic       tw_sda_o = 1'b0, tw_sda_oe = 1'b0, tw_scl_o = 1'b0;
  logic       tw_scl_oe = 1'b0, tw_sda_i, tw_scl_i;
  logic [7:0] pa_i, pa_o, pa_oe, pa_pullup, pb_i, pb_o, pb_oe;
  logic [7:0] key_irq_level, key_irq_active;
  logic [7:0] ext_a = 8'h3C, ext_a_en = 8'hFF, ext_b = 8'hC3, ext_b_en = 8'hFF;
  int         n_fail = 0, cmp_count = 0;

  always #12.5 ref_clk = ~ref_clk;

  dpg_gpio dut (.ref_clk, .rstn, .clk_en, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata, .rc_osc_sel, .tw_on_port_a, .tw_enable,
    .key_irq_pin_enable(kie), .tw_sda_o, .tw_sda_oe, .tw_scl_o, .tw_scl_oe,
    .rc_clock_output, .pa_i, .pa_o, .pa_oe, .pa_pullup, .pb_i, .pb_o,
    .pb_oe, .key_irq_level, .key_irq_active, .tw_sda_i, .tw_scl_i);
  dpg_board board (.ref_clk, .pa_o, .pa_oe, .pa_pullup, .pb_o, .pb_oe,
    .ext_a, .ext_a_en, .ext_b, .ext_b_en, .pa_i, .pb_i);

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd
  // Pin changes need two sync flops before a read sees them
  task automatic settle;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    #50000;
    n_fail++;
    report_and_stop;
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    chk(pa_oe | pb_oe | pa_pullup, 8'h00);
    rd(`DPG_OFF_PA_DIR, 8'h00);
    rd(`DPG_OFF_PB_DIR, 8'h00);
    rd(`DPG_OFF_PA_PUE, 8'h00);
    rd(8'h02, 8'h00);
    $display("test reset done");
    wr(`DPG_OFF_PA_DATA, 8'hA5);
    settle;
    rd(`DPG_OFF_PA_DATA, 8'h3C);
    ext_a_en <= 8'hF0;
    wr(`DPG_OFF_PA_DIR, 8'h0F);
    chk(pa_oe, 8'h0F);
    chk(pa_o & 8'h0F, 8'h05);
    settle;
    rd(`DPG_OFF_PA_DATA, 8'h35);
    wr(`DPG_OFF_PA_PUE, 8'hFF);
    chk(pa_pullup, 8'hF0);
    rd(`DPG_OFF_PA_PUE, 8'hFF);
    ext_a_en <= 8'h00;
    settle;
    rd(`DPG_OFF_PA_DATA, 8'hF5);
    wr(`DPG_OFF_PA_PUE, 8'h00);
    chk(pa_pullup, 8'h00);
    $display("test port a done");
    wr(`DPG_OFF_PB_DATA, 8'h5A);
    settle;
    rd(`DPG_OFF_PB_DATA, 8'hC3);
    ext_b_en <= 8'h0F;
    wr(`DPG_OFF_PB_DIR, 8'hF0);
    chk(pb_oe, 8'hF0);
    chk(pb_o & 8'hF0, 8'h50);
    settle;
    rd(`DPG_OFF_PB_DATA, 8'h53);
    $display("test port b done");
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    chk(pa_oe | pb_oe, 8'h00);
    wr(`DPG_OFF_PA_DIR, 8'hFF);
    wr(`DPG_OFF_PB_DIR, 8'hFF);
    rd(`DPG_OFF_PA_DATA, 8'hA5);
    rd(`DPG_OFF_PB_DATA, 8'h5A);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(`DPG_OFF_PA_DIR, 8'h00);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd(`DPG_OFF_PA_DIR, 8'hFF);
    $display("test mid reset done");
    wr(`DPG_OFF_PA_DIR, 8'h00);
    wr(`DPG_OFF_PIN7_PUE, 8'h80);
    rd(`DPG_OFF_PIN7_PUE, 8'h80);
    wr(`DPG_OFF_PIN7_PUE, 8'h00);
    chk(pa_oe, 8'h00);
    @(posedge ref_clk);
    rc_osc_sel <= 1'b1;
    rc_clock_output <= 1'b1;
    kie <= 8'hFF;
    wr(`DPG_OFF_PA_PUE, 8'hFF);
    chk(pa_oe, 8'h40);
    chk(pa_o & 8'h40, 8'h40);
    chk(pa_pullup, 8'hBF);
    chk(key_irq_active, 8'hBF);
    wr(`DPG_OFF_PIN7_PUE, 8'h80);
    chk(pa_oe, 8'h00);
    chk(pa_pullup, 8'hFF);
    chk(key_irq_active, 8'hFF);
    $display("test oscillator pin done");
    @(posedge ref_clk);
    tw_on_port_a <= 1'b1;
    ext_a <= 8'h00;
    ext_a_en <= 8'h08;
    wr(`DPG_OFF_PA_PUE, 8'h00);
    chk(key_irq_active, 8'hFF);
    @(posedge ref_clk);
    tw_enable <= 1'b1;
    tw_sda_oe <= 1'b1;
    tw_sda_o <= 1'b1;
    settle;
    chk(pa_oe, 8'h04);
    chk(key_irq_active, 8'hF3);
    chk({6'h00, tw_sda_i, tw_scl_i}, 8'h02);
    chk(key_irq_level & 8'h0C, 8'h04);
    @(posedge ref_clk);
    tw_sda_o <= 1'b0;
    tw_scl_oe <= 1'b1;
    tw_scl_o <= 1'b1;
    settle;
    chk(pa_oe, 8'h0C);
    chk(pa_o & 8'h0C, 8'h08);
    chk({6'h00, tw_sda_i, tw_scl_i}, 8'h01);
    $display("test two-wire done");
    report_and_stop;
  end
endmodule : testbench
